//--- core/afch_pkg.sv
package afch_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register offsets
    localparam logic [7:0] ADDR_FAULT   = 8'h08;
    localparam logic [7:0] ADDR_CLIP_UP = 8'h10;
    localparam logic [7:0] ADDR_CLIP_LO = 8'h11;
    localparam logic [7:0] ADDR_DCTL3   = 8'h13;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int BIT_OTE        = 0;
    localparam int BIT_DCE        = 1;
    localparam int BIT_OCE        = 2;
    localparam int BIT_CLOCK_ERROR_FLAG       = 3;
    localparam int FLD_CFG_LSB    = 4;
    localparam int FLD_CFG_W      = 4;
    localparam int FLD_OC_LSB     = 4;
    localparam int FLD_OC_W       = 2;
    localparam int FLD_CLIP_LSB   = 2;
    localparam int FLD_CLIP_LO_W  = 6;
    localparam int FLD_HPF_LSB    = 5;
    localparam int FLD_HPF_W      = 3;
    localparam int CLIP_LEVEL_W   = 20;
    localparam int CLIP_PROG_W    = 14;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [3:0] RST_FAULT_CFG = 4'h0;
    localparam logic [3:0] RST_FLAGS     = 4'h0;
    localparam logic [7:0] RST_CLIP_UP   = 8'hff;
    localparam logic [5:0] RST_CLIP_LO   = 6'h3f;
    localparam logic [1:0] RST_CLIP_RSV  = 2'h0;
    localparam logic [7:0] RST_DCTL3     = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Overcurrent trip point in percent of the full limit
    localparam logic [6:0] PCT_FULL    = 7'h64;
    localparam logic [6:0] PCT_THREEQ  = 7'h4b;
    localparam logic [6:0] PCT_HALF    = 7'h32;
    localparam logic [6:0] PCT_QUARTER = 7'h19;

    ////////////////////////////////////////////////////////////////////////////
    // Carriers
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } afch_reg_req_t;

    typedef struct packed {
        logic       rvalid;
        logic [7:0] rdata;
    } afch_reg_rsp_t;

    typedef struct packed {
        logic clk_err;
        logic oc;
        logic dc;
        logic ot;
    } afch_fault_t;

    typedef struct packed {
        afch_fault_t   sync1;
        afch_fault_t   sync2;
        logic [3:0]    cfg_hi;
        logic [3:0]    flags;
        logic [7:0]    clip_up;
        logic [5:0]    clip_lo;
        logic [1:0]    clip_rsv;
        logic [7:0]    dctl3;
        afch_reg_rsp_t rsp;
        logic [6:0]    trip_pct;
    } afch_state_t;

endpackage

//--- core/afch_clipper.sv
`timescale 1ns/1ns
module afch_clipper #(
    parameter int SAMPLE_W = 20,
    parameter int LEVEL_W  = 20
) (
    // Clock and reset
    input  wire logic                       clk,
    input  wire logic                       rstn,
    // Limit
    input  wire logic        [LEVEL_W-1:0]  level,
    // Samples in
    input  wire logic signed [SAMPLE_W-1:0] sample_in,
    input  wire logic                       sample_in_valid,
    // Samples out
    output logic signed      [SAMPLE_W-1:0] sample_out,
    output logic                            sample_out_valid
);
    import afch_pkg::*;

    typedef struct packed {
        logic signed [SAMPLE_W-1:0] sample;
        logic                       valid;
    } afch_clip_state_t;

    afch_clip_state_t state;
    afch_clip_state_t next_state;
    logic signed [SAMPLE_W:0] pos_lim;
    logic signed [SAMPLE_W:0] neg_lim;
    logic signed [SAMPLE_W:0] wide_in;

    // Limits carried one bit wider so the negated level never overflows
    assign pos_lim = $signed({1'b0, level[SAMPLE_W-1:0]});
    assign neg_lim = -pos_lim;
    assign wide_in = {sample_in[SAMPLE_W-1], sample_in};

    ////////////////////////////////////////////////////////////////////////////
    // Magnitude limit toward the converter
    always_comb begin
        next_state       = state;
        next_state.valid = sample_in_valid;
        if (sample_in_valid) begin
            if (wide_in > pos_lim) begin
                next_state.sample = pos_lim[SAMPLE_W-1:0];
            end else if (wide_in < neg_lim) begin
                next_state.sample = neg_lim[SAMPLE_W-1:0];
            end else begin
                next_state.sample = sample_in;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign sample_out       = state.sample;
    assign sample_out_valid = state.valid;

    chk_clip_bound: assert property (@(posedge clk) disable iff (!rstn)
        sample_out_valid |-> ($signed({sample_out[SAMPLE_W-1], sample_out}) <= $past(pos_lim))
                          && ($signed({sample_out[SAMPLE_W-1], sample_out}) >= $past(neg_lim)))
        else $error("clipped sample exceeds the level");

endmodule

//--- core/afch_regs.sv
`timescale 1ns/1ns
module afch_regs #(
    parameter int SAMPLE_W = 20
) (
    // Clock and reset
    input  wire logic                                 clk,
    input  wire logic                                 rstn,
    // Register port from the control bus engine
    input  wire afch_pkg::afch_reg_req_t              reg_req,
    output afch_pkg::afch_reg_rsp_t                   reg_rsp,
    // Fault detectors, asynchronous
    input  wire afch_pkg::afch_fault_t                fault_in,
    // Control outputs
    output logic [1:0]                                overcurrent_trip_scale,
    output logic [6:0]                                overcurrent_trip_pct,
    output logic [2:0]                                highpass_corner_sel,
    output logic [afch_pkg::CLIP_LEVEL_W-1:0]         clip_limit_level,
    output logic [3:0]                                fault_flags,
    // Sample path
    input  wire logic signed [SAMPLE_W-1:0]           sample_in,
    input  wire logic                                 sample_in_valid,
    output logic signed [SAMPLE_W-1:0]                sample_out,
    output logic                                      sample_out_valid
);
    import afch_pkg::*;

    afch_state_t state;
    afch_state_t next_state;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Trip point in percent for a scale code
    function automatic logic [6:0] trip_pct_of(input logic [1:0] code);
        logic [6:0] pct;
        case (code)
            2'h0:    pct = PCT_FULL;
            2'h1:    pct = PCT_THREEQ;
            2'h2:    pct = PCT_HALF;
            2'h3:    pct = PCT_QUARTER;
            default: pct = PCT_FULL;
        endcase
        return pct;
    endfunction

    // Write strobe aimed at one register
    function automatic logic wr_hit(input afch_reg_req_t req, input logic [7:0] addr);
        return req.wr && (req.addr == addr);
    endfunction

    // Read data as the host sees it; unmapped offsets read zero
    function automatic logic [7:0] read_mux(input afch_state_t s, input logic [7:0] addr);
        logic [7:0] d;
        case (addr)
            ADDR_FAULT:   d = {s.cfg_hi, s.flags};
            ADDR_CLIP_UP: d = s.clip_up;
            ADDR_CLIP_LO: d = {s.clip_lo, s.clip_rsv};
            ADDR_DCTL3:   d = s.dctl3;
            default:      d = 8'h00;
        endcase
        return d;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        next_state = state;

        // Detector lines cross in through two flops
        next_state.sync1 = fault_in;
        next_state.sync2 = state.sync1;

        // Configuration bits 7:4; reserved pair is simply stored
        if (wr_hit(reg_req, ADDR_FAULT)) begin
            next_state.cfg_hi = reg_req.wdata[FLD_CFG_LSB +: FLD_CFG_W];
        end
        next_state.trip_pct = trip_pct_of(next_state.cfg_hi[FLD_OC_LSB-FLD_CFG_LSB +: FLD_OC_W]);

        // Status: clock error tracks, the rest latch; a write never touches them
        next_state.flags[BIT_CLOCK_ERROR_FLAG] = state.sync2.clk_err;
        next_state.flags[BIT_OCE]  = state.flags[BIT_OCE] | state.sync2.oc;
        next_state.flags[BIT_DCE]  = state.flags[BIT_DCE] | state.sync2.dc;
        next_state.flags[BIT_OTE]  = state.flags[BIT_OTE] | state.sync2.ot;

        // Clip level halves; the low reserved pair is kept for readback
        if (wr_hit(reg_req, ADDR_CLIP_UP)) begin
            next_state.clip_up = reg_req.wdata;
        end
        if (wr_hit(reg_req, ADDR_CLIP_LO)) begin
            next_state.clip_lo  = reg_req.wdata[FLD_CLIP_LSB +: FLD_CLIP_LO_W];
            next_state.clip_rsv = reg_req.wdata[FLD_CLIP_LSB-1:0];
        end

        // Whole register stored; only the corner field steers logic here
        if (wr_hit(reg_req, ADDR_DCTL3)) begin
            next_state.dctl3 = reg_req.wdata;
        end

        // Read answer one cycle after the strobe, a single-cycle pulse
        next_state.rsp.rvalid = reg_req.rd;
        next_state.rsp.rdata  = reg_req.rd ? read_mux(state, reg_req.addr) : 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clk) begin
        if (!rstn) begin
            state          <= '0;
            state.cfg_hi   <= RST_FAULT_CFG;
            state.flags    <= RST_FLAGS;
            state.clip_up  <= RST_CLIP_UP;
            state.clip_lo  <= RST_CLIP_LO;
            state.clip_rsv <= RST_CLIP_RSV;
            state.dctl3    <= RST_DCTL3;
            state.trip_pct <= PCT_FULL;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, all taken from state flops
    assign reg_rsp                = state.rsp;
    assign overcurrent_trip_scale = state.cfg_hi[FLD_OC_LSB-FLD_CFG_LSB +: FLD_OC_W];
    assign overcurrent_trip_pct   = state.trip_pct;
    assign highpass_corner_sel    = state.dctl3[FLD_HPF_LSB +: FLD_HPF_W];
    // Only 14 bits are programmable; the top of the 20-bit level is zero
    assign clip_limit_level       = {{(CLIP_LEVEL_W-CLIP_PROG_W){1'b0}}, state.clip_up, state.clip_lo};
    assign fault_flags            = state.flags;

    ////////////////////////////////////////////////////////////////////////////
    // Clipper on the converter path; one cycle of latency, no buffering
    afch_clipper #(
        .SAMPLE_W (SAMPLE_W),
        .LEVEL_W  (CLIP_LEVEL_W)
    ) u_clipper (
        .clk              (clk),
        .rstn             (rstn),
        .level            (clip_limit_level),
        .sample_in        (sample_in),
        .sample_in_valid  (sample_in_valid),
        .sample_out       (sample_out),
        .sample_out_valid (sample_out_valid)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    chk_trip_pct_map: assert property (@(posedge clk) disable iff (!rstn)
        (overcurrent_trip_scale == 2'h0 && overcurrent_trip_pct == PCT_FULL)
     || (overcurrent_trip_scale == 2'h1 && overcurrent_trip_pct == PCT_THREEQ)
     || (overcurrent_trip_scale == 2'h2 && overcurrent_trip_pct == PCT_HALF)
     || (overcurrent_trip_scale == 2'h3 && overcurrent_trip_pct == PCT_QUARTER))
        else $error("trip percent does not match scale code");

    chk_clkerr_tracks: assert property (@(posedge clk) disable iff (!rstn)
        ($past(rstn, 1) && $past(rstn, 2) && $past(rstn, 3))
        |-> fault_flags[BIT_CLOCK_ERROR_FLAG] == $past(fault_in.clk_err, 3))
        else $error("clock error flag does not follow detector");

    chk_oc_sticky: assert property (@(posedge clk) disable iff (!rstn)
        fault_flags[BIT_OCE] |=> fault_flags[BIT_OCE] [*3])
        else $error("overcurrent flag dropped without reset");

    chk_dc_sets: assert property (@(posedge clk) disable iff (!rstn)
        state.sync2.dc |=> fault_flags[BIT_DCE] ##1 fault_flags[BIT_DCE])
        else $error("dc detect flag not latched");

    chk_ot_sets: assert property (@(posedge clk) disable iff (!rstn)
        fault_in.ot |-> ##3 fault_flags[BIT_OTE])
        else $error("over temperature flag not latched");

    chk_flags_reset: assert property (@(posedge clk) disable iff (!rstn)
        !$past(rstn) |-> fault_flags == 4'h0)
        else $error("latched flags not zero after reset");

    chk_wr_no_flags: assert property (@(posedge clk) disable iff (!rstn)
        (wr_hit(reg_req, ADDR_FAULT) && !fault_flags[BIT_OCE] && !state.sync2.oc)
        |=> !fault_flags[BIT_OCE])
        else $error("host write changed overcurrent flag");

    chk_clip_upper: assert property (@(posedge clk) disable iff (!rstn)
        wr_hit(reg_req, ADDR_CLIP_UP) |=> clip_limit_level[CLIP_PROG_W-1:FLD_CLIP_LO_W] == $past(reg_req.wdata))
        else $error("upper clip bits not stored");

    chk_clip_lower: assert property (@(posedge clk) disable iff (!rstn)
        wr_hit(reg_req, ADDR_CLIP_LO) |=> clip_limit_level[FLD_CLIP_LO_W-1:0] == $past(reg_req.wdata[7:2]))
        else $error("lower clip bits not stored");

    chk_highpass_corner_sel: assert property (@(posedge clk) disable iff (!rstn)
        wr_hit(reg_req, ADDR_DCTL3) |=> highpass_corner_sel == $past(reg_req.wdata[7:5]))
        else $error("corner select not taken from write");

    chk_rsv_readback: assert property (@(posedge clk) disable iff (!rstn)
        (wr_hit(reg_req, ADDR_CLIP_LO) ##1 (reg_req.rd && !reg_req.wr && reg_req.addr == ADDR_CLIP_LO))
        |=> reg_rsp.rvalid && reg_rsp.rdata == $past(reg_req.wdata, 2))
        else $error("lower clip register readback wrong");

    // Status latches move only on their own detector; a spurious rise would hide the first real fault
    chk_oc_sets: assert property (@(posedge clk) disable iff (!rstn)
        fault_in.oc |-> ##3 fault_flags[BIT_OCE])
        else $error("overcurrent flag not latched");

    chk_oc_no_spur: assert property (@(posedge clk) disable iff (!rstn)
        (!fault_flags[BIT_OCE] && !state.sync2.oc) |=> !fault_flags[BIT_OCE])
        else $error("overcurrent flag rose without an event");

    chk_dc_sticky: assert property (@(posedge clk) disable iff (!rstn)
        fault_flags[BIT_DCE] |=> fault_flags[BIT_DCE])
        else $error("dc detect flag dropped without reset");

    chk_dc_no_spur: assert property (@(posedge clk) disable iff (!rstn)
        (!fault_flags[BIT_DCE] && !state.sync2.dc) |=> !fault_flags[BIT_DCE])
        else $error("dc detect flag rose without an event");

    chk_ot_sticky: assert property (@(posedge clk) disable iff (!rstn)
        fault_flags[BIT_OTE] |=> fault_flags[BIT_OTE])
        else $error("over temperature flag dropped without reset");

    chk_ot_no_spur: assert property (@(posedge clk) disable iff (!rstn)
        (!fault_flags[BIT_OTE] && !state.sync2.ot) |=> !fault_flags[BIT_OTE])
        else $error("over temperature flag rose without an event");

    chk_clkerr_clears: assert property (@(posedge clk) disable iff (!rstn)
        !state.sync2.clk_err |=> !fault_flags[BIT_CLOCK_ERROR_FLAG])
        else $error("clock error flag did not clear");

    // Configuration comes up at its defaults and changes only on a write to its own offset
    chk_scale_reset: assert property (@(posedge clk) disable iff (!rstn)
        !$past(rstn) |-> overcurrent_trip_scale == 2'h0 && overcurrent_trip_pct == PCT_FULL)
        else $error("trip scale not at full after reset");

    chk_trip_scale_wr: assert property (@(posedge clk) disable iff (!rstn)
        wr_hit(reg_req, ADDR_FAULT)
        |=> overcurrent_trip_scale == $past(reg_req.wdata[FLD_OC_LSB +: FLD_OC_W]))
        else $error("trip scale not taken from write");

    chk_corner_reset: assert property (@(posedge clk) disable iff (!rstn)
        !$past(rstn) |-> highpass_corner_sel == 3'h0)
        else $error("corner select not at default after reset");

    chk_clip_reset: assert property (@(posedge clk) disable iff (!rstn)
        !$past(rstn) |-> clip_limit_level[CLIP_PROG_W-1:0] == {RST_CLIP_UP, RST_CLIP_LO})
        else $error("clip level not at its reset value");

    chk_corner_hold: assert property (@(posedge clk) disable iff (!rstn)
        !wr_hit(reg_req, ADDR_DCTL3) |=> $stable(highpass_corner_sel))
        else $error("corner select moved without a write");

    chk_clip_hold: assert property (@(posedge clk) disable iff (!rstn)
        !(wr_hit(reg_req, ADDR_CLIP_UP) || wr_hit(reg_req, ADDR_CLIP_LO)) |=> $stable(clip_limit_level))
        else $error("clip level moved without a write");

    // Read answers are a single pulse one cycle after the strobe, carrying the state seen at the strobe
    chk_rd_answer: assert property (@(posedge clk) disable iff (!rstn)
        $past(rstn) |-> reg_rsp.rvalid == $past(reg_req.rd))
        else $error("read answer not one cycle after strobe");

    chk_rsp_idle: assert property (@(posedge clk) disable iff (!rstn)
        !reg_rsp.rvalid |-> reg_rsp.rdata == 8'h00)
        else $error("read data not zero while idle");

    chk_fault_readback: assert property (@(posedge clk) disable iff (!rstn)
        (reg_req.rd && reg_req.addr == ADDR_FAULT)
        |=> reg_rsp.rdata == {$past(state.cfg_hi), $past(fault_flags)})
        else $error("fault register readback wrong");

    chk_clip_up_readback: assert property (@(posedge clk) disable iff (!rstn)
        (reg_req.rd && reg_req.addr == ADDR_CLIP_UP)
        |=> reg_rsp.rdata == $past(clip_limit_level[CLIP_PROG_W-1:FLD_CLIP_LO_W]))
        else $error("upper clip readback wrong");

    chk_clip_lo_readback: assert property (@(posedge clk) disable iff (!rstn)
        (reg_req.rd && reg_req.addr == ADDR_CLIP_LO)
        |=> reg_rsp.rdata[7:FLD_CLIP_LSB] == $past(clip_limit_level[FLD_CLIP_LO_W-1:0]))
        else $error("lower clip readback wrong");

    chk_corner_readback: assert property (@(posedge clk) disable iff (!rstn)
        (reg_req.rd && reg_req.addr == ADDR_DCTL3)
        |=> reg_rsp.rdata[FLD_HPF_LSB +: FLD_HPF_W] == $past(highpass_corner_sel))
        else $error("corner readback wrong");

    // Sample path from outside: one cycle late, clamped to the level held at the input edge
    chk_out_valid: assert property (@(posedge clk) disable iff (!rstn)
        $past(rstn) |-> sample_out_valid == $past(sample_in_valid))
        else $error("sample valid not one cycle after input");

    chk_clip_pos: assert property (@(posedge clk) disable iff (!rstn)
        (sample_in_valid && !sample_in[SAMPLE_W-1] && ($unsigned(sample_in) > clip_limit_level))
        |=> $unsigned(sample_out) == $past(clip_limit_level))
        else $error("positive sample not held at the level");

    chk_clip_pass: assert property (@(posedge clk) disable iff (!rstn)
        (sample_in_valid && !sample_in[SAMPLE_W-1] && ($unsigned(sample_in) <= clip_limit_level))
        |=> sample_out == $past(sample_in))
        else $error("sample inside the level was altered");

endmodule

//--- tb/afch_host.sv
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// Host controller model: issues one register request per task (a write then a read in wr_rd), driven on the falling edge
module afch_host (
    // Clock
    input  wire logic                    clk,
    // Register port
    output afch_pkg::afch_reg_req_t      req,
    input  wire afch_pkg::afch_reg_rsp_t rsp
);
    import afch_pkg::*;

    initial req = '0;

    // Reserved bits are masked to zero, since the device may give them meaning later
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] m;
        m = (a == ADDR_FAULT) ? (d & 8'h3f) : d;
        m = (a == ADDR_CLIP_LO) ? (m & 8'hfc) : m;
        @(negedge clk);
        req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: m};
        @(negedge clk);
        // Released lines show garbage, not the last value
        req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~m};
    endtask

    // Read data is taken in the one cycle that rvalid stands
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h5a};
        @(negedge clk);
        req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'ha5};
        d = (rsp.rvalid === 1'b1) ? rsp.rdata : 8'hxx;
    endtask

    // Write then read the same offset on the very next edge, to catch readback of fresh state
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        logic [7:0] m;
        m = (a == ADDR_FAULT) ? (d & 8'h3f) : d;
        m = (a == ADDR_CLIP_LO) ? (m & 8'hfc) : m;
        @(negedge clk);
        req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: m};
        @(negedge clk);
        req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: ~m};
        @(negedge clk);
        req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'ha5};
        q = (rsp.rvalid === 1'b1) ? rsp.rdata : 8'hxx;
    endtask
endmodule

//--- tb/afch_regs_tb.sv
`timescale 1ns/1ns
module afch_regs_tb;
    import afch_pkg::*;

    logic                 clk = 1'b0;
    logic                 rstn = 1'b0;
    afch_reg_req_t        req;
    afch_reg_rsp_t        rsp;
    afch_fault_t          flt = '0;
    logic [1:0]           scale;
    logic [6:0]           pct;
    logic [2:0]           hpf;
    logic [19:0]          lvl;
    logic [3:0]           flags;
    logic signed [19:0]   sin = '0;
    logic                 sv = 1'b0;
    logic signed [19:0]   sout;
    logic                 sov;
    int                   mismatches = 0;
    int                   total_checks = 0;
    logic [6:0]           pct_tab [4] = '{PCT_FULL, PCT_THREEQ, PCT_HALF, PCT_QUARTER};
    logic [19:0]          s_in [5] = '{20'h02958, 20'h02957, 20'hfd6a8, 20'h80000, 20'h00123};
    logic [19:0]          s_exp [5] = '{20'h02957, 20'h02957, 20'hfd6a9, 20'hfd6a9, 20'h00123};

    always #2 clk = ~clk;

    afch_host host (.clk(clk), .req(req), .rsp(rsp));

    afch_regs dut (
        .clk(clk), .rstn(rstn), .reg_req(req), .reg_rsp(rsp), .fault_in(flt),
        .overcurrent_trip_scale(scale), .overcurrent_trip_pct(pct), .highpass_corner_sel(hpf),
        .clip_limit_level(lvl), .fault_flags(flags), .sample_in(sin), .sample_in_valid(sv),
        .sample_out(sout), .sample_out_valid(sov)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Comparison helpers
    task automatic chk(input string n, input logic [19:0] s, input logic [19:0] e);
        total_checks++;
        if (s !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic rdchk(input string n, input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        host.rd(a, d);
        chk(n, {12'h0, d}, {12'h0, e});
    endtask

    task automatic close_out();
        $display("Checks %0d, mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset();
        chk("flags", flags, 4'h0);
        chk("pct", pct, PCT_FULL);
        chk("level", lvl, 20'h03fff);
        rdchk("fault reg", ADDR_FAULT, 8'h00);
        rdchk("clip up", ADDR_CLIP_UP, 8'hff);
        rdchk("clip lo", ADDR_CLIP_LO, 8'hfc);
        rdchk("dctl3", ADDR_DCTL3, 8'h00);
        rdchk("unmapped", 8'h20, 8'h00);
        $display("test reset done");
    endtask

    task automatic t_trip();
        for (int c = 0; c < 4; c++) begin
            host.wr(ADDR_FAULT, {2'b11, c[1:0], 4'h0});
            chk("scale", scale, c[1:0]);
            chk("pct", pct, pct_tab[c]);
            rdchk("fault reg", ADDR_FAULT, {2'b00, c[1:0], 4'h0});
        end
        $display("test trip scale done");
    endtask

    // Limit is 0x2957; edges just inside and outside on the positive side, outside only on the negative side
    task automatic t_clip();
        logic [7:0] d;
        host.wr(ADDR_CLIP_UP, 8'ha5);
        host.wr_rd(ADDR_CLIP_LO, 8'h5f, d);
        chk("level", lvl, 20'h02957);
        chk("clip lo", {12'h0, d}, 20'h0005c);
        for (int i = 0; i < 5; i++) begin
            @(negedge clk);
            sin = s_in[i];
            sv = 1'b1;
            @(negedge clk);
            sv = 1'b0;
            chk("out valid", {19'h0, sov}, 20'h1);
            chk("sample out", sout, s_exp[i]);
        end
        $display("test clipper done");
    endtask

    task automatic t_hpf();
        for (int c = 0; c < 8; c++) begin
            host.wr(ADDR_DCTL3, {c[2:0], 5'h0});
            chk("corner", hpf, c[2:0]);
            rdchk("dctl3", ADDR_DCTL3, {c[2:0], 5'h0});
        end
        $display("test corner done");
    endtask

    // Flags settle three edges after the detector pin moves
    task automatic t_fault();
        @(negedge clk);
        flt.clk_err = 1'b1;
        repeat (2) @(negedge clk);
        chk("clk err early", flags[3], 1'b0);
        @(negedge clk);
        chk("clk err set", flags[3], 1'b1);
        flt.clk_err = 1'b0;
        repeat (3) @(negedge clk);
        chk("clk err clear", flags[3], 1'b0);
        for (int b = 0; b < 3; b++) begin
            @(negedge clk);
            flt[b] = 1'b1;
            @(negedge clk);
            flt[b] = 1'b0;
            repeat (2) @(negedge clk);
            chk("latch set", flags[b], 1'b1);
        end
        repeat (5) @(negedge clk);
        chk("latched", flags, 4'h7);
        host.wr(ADDR_FAULT, 8'h00);
        chk("after write", flags, 4'h7);
        rdchk("fault reg", ADDR_FAULT, 8'h07);
        rstn = 1'b0;
        repeat (3) @(negedge clk);
        rstn = 1'b1;
        chk("after reset", flags, 4'h0);
        $display("test faults done");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence and watchdog
    initial begin
        repeat (3) @(negedge clk);
        rstn = 1'b1;
        t_reset();
        t_trip();
        t_clip();
        t_hpf();
        t_fault();
        close_out();
    end

    // All scenarios take about 110 cycles; this leaves wide margin
    initial begin
        #20000;
        mismatches++;
        close_out();
    end
endmodule
